// [src/biex_exec.sv]
// Execution datapath for add, AND, bit clear/set and bit-test-skip.
// Assumes an AXI4-Lite master that keeps one write and one read at a time.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - add_immediate_to_acc sums accumulator and literal into accumulator.
// - add_acc_with_register sums accumulator and file register, updates flags.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - clear_register_bit zeroes the selected bit, flags unchanged.
// - set_register_bit sets the selected bit, flags unchanged.
// - and_immediate_with_acc ANDs literal into accumulator, only zero flag.
// - and_acc_with_register ANDs, routes by destination, only zero flag.
// - skip_when_bit_high discards next instruction when bit is one.
// - skip_when_bit_low discards next instruction when bit is zero.
// - Destination one means file register, zero means accumulator.
// - The I/O port register reads its pins as operand.
// - A true conditional test takes two cycles, second is idle.
module biex_exec (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // I/O port
  input  wire logic [7:0]  pins_in,
  output logic [7:0]       port_out
);
  // ==========================================================================
  // State and datapath signals
  biex_pkg::biex_state_s_t q;
  biex_pkg::biex_state_s_t d;
  localparam biex_pkg::biex_state_s_t RST = '{
    st: biex_pkg::S_IDLE, awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
    bresp: biex_pkg::RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
    rresp: biex_pkg::RESP_OKAY, rdata: 32'h0000_0000, aw_got: 1'b0,
    w_got: 1'b0, waddr: 8'h00, wdata: 32'h0000_0000, wlane0: 1'b0,
    raddr: 8'h00, acc: biex_pkg::ACC_RESET, zero: 1'b0, carry: 1'b0,
    half: 1'b0, skip: 1'b0, port_out: 8'h00, file_addr: 7'h00};
  biex_pkg::biex_op_t op;
  logic [7:0] lit, mask, mem_rdata, opnd, addend, and_res, res, mem_wdata;
  logic [6:0] cmd_addr, sel_addr, mem_waddr, mem_raddr;
  logic [2:0] bitpos;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic       dest, tbit, skip_now, to_reg, mem_we;
  logic       aw_now, w_now, ar_now, aw_all, w_all;

  assign op       = biex_pkg::biex_op_t'(q.wdata[biex_pkg::CMD_OP_LSB +: 4]);
  assign lit      = q.wdata[biex_pkg::CMD_LIT_LSB +: 8];
  assign cmd_addr = q.wdata[biex_pkg::CMD_ADDR_LSB +: 7];
  assign bitpos   = q.wdata[biex_pkg::CMD_BIT_LSB +: 3];
  assign dest     = q.wdata[biex_pkg::CMD_DEST_POS];
  assign mask     = 8'h01 << bitpos;
  assign sel_addr = (q.st == biex_pkg::S_RMUX) ? q.file_addr : cmd_addr;
  assign opnd     = (sel_addr == biex_pkg::IO_PORT_ADDR) ? pins_in
                                                         : mem_rdata;
  assign addend   = (op == biex_pkg::OP_ADD_IMM) ? lit : opnd;
  assign sum9     = {1'b0, q.acc} + {1'b0, addend};
  assign sum5     = {1'b0, q.acc[3:0]} + {1'b0, addend[3:0]};
  assign and_res  = q.acc & ((op == biex_pkg::OP_AND_IMM) ? lit : opnd);
  assign tbit     = |(opnd & mask);
  assign skip_now = ((op == biex_pkg::OP_SKIP_HIGH) && tbit) ||
                    ((op == biex_pkg::OP_SKIP_LOW) && !tbit);
  assign to_reg   = dest && ((op == biex_pkg::OP_ADD_REG) ||
                             (op == biex_pkg::OP_AND_REG));
  assign mem_raddr = (q.st == biex_pkg::S_RDEC) ? q.file_addr : cmd_addr;
  assign aw_now   = s_axi_awvalid && q.awready;
  assign w_now    = s_axi_wvalid && q.wready;
  assign ar_now   = s_axi_arvalid && q.arready;
  assign aw_all   = q.aw_got || aw_now;
  assign w_all    = q.w_got || w_now;
  always_comb begin
    res = 8'h00;
    case (op)
      biex_pkg::OP_ADD_IMM, biex_pkg::OP_ADD_REG: res = sum9[7:0];
      biex_pkg::OP_AND_IMM, biex_pkg::OP_AND_REG: res = and_res;
      biex_pkg::OP_CLR_BIT: res = opnd & ~mask;
      biex_pkg::OP_SET_BIT: res = opnd | mask;
      default: res = opnd;
    endcase
  end

  // ==========================================================================
  // File register write port
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = cmd_addr;
    mem_wdata = res;
    if (q.st == biex_pkg::S_EXEC) begin
      mem_we = to_reg || (op == biex_pkg::OP_CLR_BIT) ||
               (op == biex_pkg::OP_SET_BIT);
    end else if ((q.st == biex_pkg::S_WDEC) && q.wlane0 &&
                 (q.waddr == biex_pkg::ADDR_FILE_DATA)) begin
      mem_we    = 1'b1;
      mem_waddr = q.file_addr;
      mem_wdata = q.wdata[7:0];
    end
  end
  biex_file_mem u_mem (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (mem_raddr),
    .rdata_q  (mem_rdata)
  );

  // ==========================================================================
  // Bus sequencing and execution
  always_comb begin
    d = q;
    case (q.st)
      biex_pkg::S_IDLE: begin
        if (aw_now) begin
          d.aw_got = 1'b1;
          d.waddr  = s_axi_awaddr;
        end
        if (w_now) begin
          d.w_got  = 1'b1;
          d.wdata  = s_axi_wdata;
          d.wlane0 = s_axi_wstrb[0];
        end
        d.awready = !aw_all;
        d.wready  = !w_all;
        d.arready = !(aw_all && w_all);
        if (ar_now) begin
          d.raddr   = s_axi_araddr;
          d.awready = 1'b0;
          d.wready  = 1'b0;
          d.arready = 1'b0;
          d.st      = biex_pkg::S_RDEC;
        end else if (aw_all && w_all) begin
          d.awready = 1'b0;
          d.wready  = 1'b0;
          d.arready = 1'b0;
          d.st      = biex_pkg::S_WDEC;
        end
      end
      biex_pkg::S_WDEC: begin
        d.bresp  = biex_pkg::RESP_OKAY;
        d.bvalid = 1'b1;
        d.st     = biex_pkg::S_BRSP;
        case (q.waddr)
          biex_pkg::ADDR_CMD: begin
            if (q.skip) begin
              d.skip = 1'b0;
            end else if (op != biex_pkg::OP_IDLE_SLOT) begin
              d.bvalid = 1'b0;
              d.st     = biex_pkg::S_EXEC;
            end
          end
          biex_pkg::ADDR_ACC: if (q.wlane0) d.acc = q.wdata[7:0];
          biex_pkg::ADDR_STATUS: begin
            if (q.wlane0) begin
              d.zero  = q.wdata[biex_pkg::ST_ZERO_POS];
              d.carry = q.wdata[biex_pkg::ST_CARRY_POS];
              d.half  = q.wdata[biex_pkg::ST_HALF_POS];
            end
          end
          biex_pkg::ADDR_FILE_ADDR: if (q.wlane0) d.file_addr = q.wdata[6:0];
          biex_pkg::ADDR_FILE_DATA: begin
            if (q.wlane0 && (q.file_addr == biex_pkg::IO_PORT_ADDR)) begin
              d.port_out = q.wdata[7:0];
            end
          end
          biex_pkg::ADDR_PINS,
          biex_pkg::ADDR_PORT: d.bresp = biex_pkg::RESP_OKAY;
          default: d.bresp = biex_pkg::RESP_SLVERR;
        endcase
      end
      biex_pkg::S_EXEC: begin
        d.bvalid = 1'b1;
        d.st     = biex_pkg::S_BRSP;
        case (op)
          biex_pkg::OP_ADD_IMM, biex_pkg::OP_ADD_REG: begin
            d.carry = sum9[8];
            d.half  = sum5[4];
            d.zero  = (res == 8'h00);
          end
          biex_pkg::OP_AND_IMM, biex_pkg::OP_AND_REG: begin
            d.zero = (res == 8'h00);
          end
          default: d.zero = q.zero;
        endcase
        if (!to_reg && (op inside {biex_pkg::OP_ADD_IMM,
            biex_pkg::OP_ADD_REG, biex_pkg::OP_AND_IMM,
            biex_pkg::OP_AND_REG})) begin
          d.acc = res;
        end
        if (mem_we && (cmd_addr == biex_pkg::IO_PORT_ADDR)) d.port_out = res;
        if (skip_now) begin
          d.bvalid = 1'b0;
          d.st     = biex_pkg::S_SKIP;
        end
      end
      biex_pkg::S_SKIP: begin
        d.skip   = 1'b1;
        d.bvalid = 1'b1;
        d.st     = biex_pkg::S_BRSP;
      end
      biex_pkg::S_BRSP: begin
        if (s_axi_bready) begin
          d.bvalid  = 1'b0;
          d.aw_got  = 1'b0;
          d.w_got   = 1'b0;
          d.awready = 1'b1;
          d.wready  = 1'b1;
          d.arready = 1'b1;
          d.st      = biex_pkg::S_IDLE;
        end
      end
      biex_pkg::S_RDEC: d.st = biex_pkg::S_RMUX;
      biex_pkg::S_RMUX: begin
        d.rvalid = 1'b1;
        d.rresp  = biex_pkg::RESP_OKAY;
        d.rdata  = 32'h0000_0000;
        d.st     = biex_pkg::S_RRSP;
        case (q.raddr)
          biex_pkg::ADDR_CMD:       d.rdata = 32'h0000_0000;
          biex_pkg::ADDR_ACC:       d.rdata[7:0] = q.acc;
          biex_pkg::ADDR_STATUS:    d.rdata[3:0] = {q.skip, q.half,
                                                    q.carry, q.zero};
          biex_pkg::ADDR_FILE_ADDR: d.rdata[6:0] = q.file_addr;
          biex_pkg::ADDR_FILE_DATA: d.rdata[7:0] = opnd;
          biex_pkg::ADDR_PINS:      d.rdata[7:0] = pins_in;
          biex_pkg::ADDR_PORT:      d.rdata[7:0] = q.port_out;
          default:                  d.rresp = biex_pkg::RESP_SLVERR;
        endcase
      end
      biex_pkg::S_RRSP: begin
        if (s_axi_rready) begin
          d.rvalid  = 1'b0;
          d.awready = !q.aw_got;
          d.wready  = !q.w_got;
          d.arready = !(q.aw_got && q.w_got);
          d.st      = biex_pkg::S_IDLE;
        end
      end
      default: d = RST;
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign port_out      = q.port_out;

  // ==========================================================================
  // Checks
  logic       in_exec, ex_carry;
  logic [7:0] q_acc;
  assign in_exec  = (q.st == biex_pkg::S_EXEC);
  assign ex_carry = sum9[8];
  assign q_acc    = q.acc;
  sequence s_skip_taken;
    in_exec && skip_now;
  endsequence
  sequence s_skip_slot;
    (q.st == biex_pkg::S_SKIP) ##1 (q.bvalid && q.skip);
  endsequence
  chk_add_imm_sum: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_ADD_IMM) |=>
    q_acc == 8'($past(q_acc) + $past(lit))) else $error("bad add sum");
  chk_add_reg_carry: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_ADD_REG) |=>
    q.carry == $past(ex_carry)) else $error("add register carry wrong");
  chk_dest_routing: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op inside {biex_pkg::OP_ADD_REG,
    biex_pkg::OP_AND_REG}) |-> (mem_we == dest) ##1
    (dest || (q_acc == $past(res)))) else $error("bad destination routing");
  chk_clear_bit: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_CLR_BIT) |->
    mem_we && ((mem_wdata & mask) == 8'h00) &&
    ((mem_wdata | mask) == (opnd | mask)) ##1 $stable(q.zero))
    else $error("bit clear wrong");
  chk_set_bit: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_SET_BIT) |->
    mem_we && (mem_wdata == (opnd | mask)) ##1 $stable(q.carry))
    else $error("bit set wrong");
  chk_and_imm_flags: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_AND_IMM) |=>
    $stable(q.carry) && $stable(q.half) && (q.zero == (q_acc == 8'h00)))
    else $error("and immediate flags wrong");
  chk_and_reg_zero: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_AND_REG) |=>
    q.zero == ($past(and_res) == 8'h00)) else $error("and zero flag wrong");
  chk_skip_two_cyc: assert property (@(posedge core_clk)
    disable iff (!arst_n) s_skip_taken |=> s_skip_slot)
    else $error("skip did not take an idle slot");
  chk_skip_low_test: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_SKIP_LOW) && tbit
    |=> q.bvalid && !q.skip) else $error("skip on low bit taken wrongly");
  chk_io_operand: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_ADD_REG) &&
    (cmd_addr == biex_pkg::IO_PORT_ADDR) |=> (dest ? q.port_out : q_acc)
    == 8'($past(q_acc) + $past(pins_in))) else $error("port operand wrong");
  chk_zero_flag: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && (op == biex_pkg::OP_ADD_IMM) |=>
    q.zero == (q_acc == 8'h00)) else $error("zero flag wrong");
  chk_single_cycle: assert property (@(posedge core_clk)
    disable iff (!arst_n) in_exec && !skip_now |=> q.bvalid)
    else $error("write response late");
endmodule // biex_exec

// [src/biex_pkg.sv]
// Constants, register map and types for the bit and arithmetic executor.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package biex_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_ACC       = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_FILE_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h10;
  localparam logic [7:0] ADDR_PINS      = 8'h14;
  localparam logic [7:0] ADDR_PORT      = 8'h18;

  // ==========================================================================
  // Command word field positions
  localparam int CMD_LIT_LSB  = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_BIT_LSB  = 15;
  localparam int CMD_DEST_POS = 18;
  localparam int CMD_OP_LSB   = 20;

  // ==========================================================================
  // Status field positions
  localparam int ST_ZERO_POS = 0;
  localparam int ST_CARRY_POS = 1;
  localparam int ST_HALF_POS = 2;
  localparam int ST_SKIP_POS = 3;

  // ==========================================================================
  // File address of the I/O port register, reset value and response codes
  localparam logic [6:0] IO_PORT_ADDR = 7'h05;
  localparam logic [7:0] ACC_RESET    = 8'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [3:0] {
    OP_ADD_IMM   = 4'h0,
    OP_ADD_REG   = 4'h1,
    OP_AND_IMM   = 4'h2,
    OP_AND_REG   = 4'h3,
    OP_CLR_BIT   = 4'h4,
    OP_SET_BIT   = 4'h5,
    OP_SKIP_HIGH = 4'h6,
    OP_SKIP_LOW  = 4'h7,
    OP_IDLE_SLOT = 4'h8
  } biex_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WDEC = 3'h1,
    S_EXEC = 3'h2,
    S_SKIP = 3'h3,
    S_BRSP = 3'h4,
    S_RDEC = 3'h5,
    S_RMUX = 3'h6,
    S_RRSP = 3'h7
  } biex_state_t;

  typedef struct packed {
    biex_state_t st;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic        wlane0;
    logic [7:0]  raddr;
    logic [7:0]  acc;
    logic        zero;
    logic        carry;
    logic        half;
    logic        skip;
    logic [7:0]  port_out;
    logic [6:0]  file_addr;
  } biex_state_s_t;

endpackage

// [src/biex_file_mem.sv]
// File register space of 128 bytes with a registered read port.
// Assumes writes and reads are issued by one owner on the core clock.
`timescale 1ns/100ps
module biex_file_mem (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Write port
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  // Read port
  input  wire logic [6:0] raddr,
  output logic      [7:0] rdata_q
);
  logic [7:0] mem [128];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // biex_file_mem

// [verification/biex_tb.sv]
// Self-checking testbench for the bit and arithmetic executor.
// Assumes the AXI4-Lite register map and command word of biex_pkg.
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // Design signals and bench state
  logic        core_clk;
  logic        arst_n;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  pins_in;
  logic [7:0]  port_out;
  int          mismatches;
  int          n_checks;
  int          lat;
  int          lat_plain;
  logic [31:0] rd;
  logic [1:0]  resp;
  logic [7:0]  acc_e;
  biex_pkg::biex_op_t sk_op [4] = '{biex_pkg::OP_SKIP_HIGH,
    biex_pkg::OP_SKIP_HIGH, biex_pkg::OP_SKIP_LOW, biex_pkg::OP_SKIP_LOW};
  logic [2:0]  sk_bit [4] = '{3'h2, 3'h3, 3'h3, 3'h2};
  logic        sk_hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  biex_exec u_dut (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (wstrb),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready),
    .pins_in       (pins_in),
    .port_out      (port_out)
  );

  // ==========================================================================
  // Comparison and closing report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic timed_out();
    mismatches++;
    $display("Error at %0t: bus answer never came", $time);
    conclude();
  endtask

  // ==========================================================================
  // Bus tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    bit done;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    done = 1'b0;
    lat = -1;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    repeat (100) begin
      @(posedge core_clk);
      if (lat >= 0) lat++;
      if (awvalid === 1'b1 && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (aw_ok && w_ok && lat < 0) lat = 0;
      if (bvalid === 1'b1 && lat > 0) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
        break;
      end
    end
    if (!done) timed_out();
  endtask

  task automatic axi_read(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    repeat (100) begin
      @(posedge core_clk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && arvalid === 1'b0) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
        break;
      end
    end
    if (!done) timed_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d);
    chk({30'h0, resp}, {30'h0, biex_pkg::RESP_OKAY});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    chk(rd, exp);
    chk({30'h0, resp}, {30'h0, biex_pkg::RESP_OKAY});
  endtask

  task automatic cmd(input biex_pkg::biex_op_t op, input logic [7:0] lit,
                     input logic [6:0] fa, input logic [2:0] b,
                     input logic dest);
    wr(biex_pkg::ADDR_CMD, {8'h00, op, 1'b0, dest, b, fa, lit});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, pins_in} = '0;
    wstrb = 4'h1;
    arst_n = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    rc(biex_pkg::ADDR_ACC, 32'h0000_0000);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0000);
    chk({24'h0, port_out}, 32'h0000_0000);
    cmd(biex_pkg::OP_ADD_IMM, 8'h8F, 7'h00, 3'h0, 1'b1);
    cmd(biex_pkg::OP_ADD_IMM, 8'h81, 7'h00, 3'h0, 1'b1);
    rc(biex_pkg::ADDR_ACC, 32'h0000_0010);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0006);
    cmd(biex_pkg::OP_AND_IMM, 8'h30, 7'h00, 3'h0, 1'b1);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0006);
    cmd(biex_pkg::OP_AND_IMM, 8'h0F, 7'h00, 3'h0, 1'b1);
    rc(biex_pkg::ADDR_ACC, 32'h0000_0000);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0007);
    wr(biex_pkg::ADDR_FILE_ADDR, 32'h0000_007F);
    wr(biex_pkg::ADDR_FILE_DATA, 32'h0000_00F0);
    cmd(biex_pkg::OP_ADD_IMM, 8'h1F, 7'h00, 3'h0, 1'b0);
    cmd(biex_pkg::OP_ADD_REG, 8'h00, 7'h7F, 3'h0, 1'b0);
    rc(biex_pkg::ADDR_ACC, 32'h0000_000F);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0002);
    cmd(biex_pkg::OP_ADD_REG, 8'h00, 7'h7F, 3'h0, 1'b1);
    rc(biex_pkg::ADDR_FILE_DATA, 32'h0000_00FF);
    rc(biex_pkg::ADDR_ACC, 32'h0000_000F);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0000);
    cmd(biex_pkg::OP_AND_REG, 8'h00, 7'h7F, 3'h0, 1'b1);
    rc(biex_pkg::ADDR_FILE_DATA, 32'h0000_000F);
    cmd(biex_pkg::OP_ADD_IMM, 8'h31, 7'h00, 3'h0, 1'b0);
    cmd(biex_pkg::OP_AND_REG, 8'h00, 7'h7F, 3'h0, 1'b0);
    rc(biex_pkg::ADDR_ACC, 32'h0000_0000);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0005);
    rc(biex_pkg::ADDR_FILE_DATA, 32'h0000_000F);
    wr(biex_pkg::ADDR_FILE_DATA, 32'h0000_0000);
    for (int b = 0; b < 8; b++) begin
      cmd(biex_pkg::OP_SET_BIT, 8'hFF, 7'h7F, 3'(b), 1'b0);
      rc(biex_pkg::ADDR_FILE_DATA, 32'h0000_00FF >> (7 - b));
    end
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0005);
    for (int b = 0; b < 8; b++) begin
      cmd(biex_pkg::OP_CLR_BIT, 8'hFF, 7'h7F, 3'(b), 1'b0);
      rc(biex_pkg::ADDR_FILE_DATA,
         (32'h0000_00FF << (b + 1)) & 32'h0000_00FF);
    end
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0005);
    wr(biex_pkg::ADDR_FILE_DATA, 32'h0000_0004);
    cmd(biex_pkg::OP_ADD_IMM, 8'h00, 7'h00, 3'h0, 1'b0);
    lat_plain = lat;
    acc_e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      cmd(sk_op[i], 8'h00, 7'h7F, sk_bit[i], 1'b0);
      chk(lat - lat_plain, {31'h0, sk_hit[i]});
      axi_read(biex_pkg::ADDR_STATUS);
      chk({31'h0, rd[biex_pkg::ST_SKIP_POS]}, {31'h0, sk_hit[i]});
      cmd(biex_pkg::OP_ADD_IMM, 8'h01, 7'h00, 3'h0, 1'b0);
      acc_e = acc_e + {7'h00, ~sk_hit[i]};
      rc(biex_pkg::ADDR_ACC, {24'h0, acc_e});
      axi_read(biex_pkg::ADDR_STATUS);
      chk({31'h0, rd[biex_pkg::ST_SKIP_POS]}, 32'h0000_0000);
    end
    cmd(biex_pkg::OP_IDLE_SLOT, 8'h55, 7'h7F, 3'h0, 1'b0);
    rc(biex_pkg::ADDR_ACC, 32'h0000_0002);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0000);
    @(posedge core_clk);
    pins_in <= 8'hA5;
    wr(biex_pkg::ADDR_FILE_ADDR, 32'h0000_0005);
    rc(biex_pkg::ADDR_FILE_DATA, 32'h0000_00A5);
    rc(biex_pkg::ADDR_PINS, 32'h0000_00A5);
    cmd(biex_pkg::OP_ADD_REG, 8'h00, 7'h05, 3'h0, 1'b1);
    chk({24'h0, port_out}, 32'h0000_00A7);
    rc(biex_pkg::ADDR_PORT, 32'h0000_00A7);
    @(posedge core_clk);
    pins_in <= 8'h0F;
    cmd(biex_pkg::OP_ADD_REG, 8'h00, 7'h05, 3'h0, 1'b0);
    rc(biex_pkg::ADDR_ACC, 32'h0000_0011);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0004);
    cmd(biex_pkg::OP_AND_REG, 8'h00, 7'h05, 3'h0, 1'b1);
    chk({24'h0, port_out}, 32'h0000_0001);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0004);
    rc(biex_pkg::ADDR_CMD, 32'h0000_0000);
    wstrb <= 4'h0;
    wr(biex_pkg::ADDR_ACC, 32'h0000_00EE);
    wstrb <= 4'h1;
    rc(biex_pkg::ADDR_ACC, 32'h0000_0011);
    wr(biex_pkg::ADDR_STATUS, 32'h0000_000F);
    rc(biex_pkg::ADDR_STATUS, 32'h0000_0007);
    axi_write(8'h1C, 32'h0000_00FF);
    chk({30'h0, resp}, {30'h0, biex_pkg::RESP_SLVERR});
    axi_read(8'h1C);
    chk({30'h0, resp}, {30'h0, biex_pkg::RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    wr(biex_pkg::ADDR_PINS, 32'h0000_0033);
    rc(biex_pkg::ADDR_PINS, 32'h0000_000F);
    conclude();
  end
endmodule // testbench
